// *** dv/ahb_mem_model.sv ***
/*
  AHB arbiter and word memory of 64 entries on the controller's far side.
  Assumes word writes only; slow inserts a wait state every other cycle.
*/
`timescale 1ns/1ps

module ahb_mem_model (
  input  wire        core_clk,
  input  wire        resetn,
  input  wire        slow,
  input  wire        hbusreq_q,
  input  wire [1:0]  htrans_q,
  input  wire [31:0] haddr_q,
  input  wire        hwrite_q,
  input  wire [31:0] hwdata_q,
  output logic       hgrant,
  output logic       hready,
  output wire [31:0] hrdata
);
  logic [31:0] mem [0:63];
  logic        wr_pend;
  logic        rd_pend;
  logic [5:0]  ph_addr;

  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      hgrant  <= 1'b0;
      hready  <= 1'b1;
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
    end
    else
    begin
      // Grant kept through a stalled address phase
      hgrant <= hbusreq_q | (hgrant & htrans_q[1] & ~hready);
      hready <= slow ? ~hready : 1'b1;
      if (hready)
      begin
        if (wr_pend)
          mem[ph_addr] <= hwdata_q;
        wr_pend <= htrans_q[1] & hwrite_q;
        rd_pend <= htrans_q[1] & ~hwrite_q;
        ph_addr <= haddr_q[7:2];
      end
    end
  end

  // Outside a read data phase the bus shows junk, not stale data
  assign hrdata = rd_pend ? mem[ph_addr] : ~mem[ph_addr];
endmodule // ahb_mem_model

// *** dv/pdma_monitor.sv ***
/*
  Port assertions for the peripheral DMA controller.
  Assumes one core clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`include "pdma_defines.vh"

module pdma_monitor (
  input wire        core_clk,
  input wire        resetn,
  input wire [9:0]  per_req,
  input wire [9:0]  per_ack_q,
  input wire        desc_wr,
  input wire [3:0]  desc_ch,
  input wire        desc_ready_q,
  input wire [9:0]  irq_enable,
  input wire [9:0]  buf_need_q,
  input wire        irq_q,
  input wire        hgrant,
  input wire        hready,
  input wire [31:0] haddr_q,
  input wire [1:0]  htrans_q,
  input wire [2:0]  hsize_q,
  input wire [2:0]  hburst_q
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  property p_irq;
    irq_q == $past(|(buf_need_q & irq_enable));
  endproperty
  a_irq: assert property (p_irq) else $error("irq does not follow masked need");

  property p_ack_gap;
    (per_ack_q & $past(per_ack_q)) == 10'h000;
  endproperty
  a_ack_gap: assert property (p_ack_gap) else $error("ack on two cycles running");

  // Receive acks must answer a word that was really offered
  property p_rx_ack;
    (per_ack_q & 10'h38A & ~$past(per_req)) == 10'h000;
  endproperty
  a_rx_ack: assert property (p_rx_ack) else $error("rx ack without request");

  property p_grant;
    $rose(htrans_q[1]) |-> $past(hgrant && hready);
  endproperty
  a_grant: assert property (p_grant) else $error("transfer without bus grant");

  property p_quad_size;
    htrans_q == `HTRANS_NONSEQ && hburst_q == `HBURST_INCR4 |-> hsize_q == `HSIZE_WORD;
  endproperty
  a_quad_size: assert property (p_quad_size) else $error("burst not word sized");

  property p_burst_seq;
    htrans_q == `HTRANS_NONSEQ && hburst_q == `HBURST_INCR4 && hready
      |-> ##[1:8] htrans_q == `HTRANS_SEQ;
  endproperty
  a_burst_seq: assert property (p_burst_seq) else $error("burst not continued");

  property p_seq_addr;
    htrans_q == `HTRANS_SEQ && $past(hready) && $past(htrans_q[1])
      |-> haddr_q == $past(haddr_q) + 32'h00000004;
  endproperty
  a_seq_addr: assert property (p_seq_addr) else $error("burst address not +4");

  property p_size;
    htrans_q[1] |-> hsize_q == `HSIZE_BYTE || hsize_q == `HSIZE_WORD;
  endproperty
  a_size: assert property (p_size) else $error("illegal transfer size");

  property p_ready_pulse;
    $fell(desc_ready_q) |=> desc_ready_q;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("descriptor port blocked");

  property p_need_clr;
    desc_wr && desc_ready_q |=> buf_need_q[$past(desc_ch)] == 1'b0;
  endproperty
  a_need_clr: assert property (p_need_clr) else $error("buffer need not cleared");
endmodule // pdma_monitor

bind peripheral_dma_controller pdma_monitor pdma_monitor_inst (
  .core_clk(core_clk), .resetn(resetn), .per_req(per_req), .per_ack_q(per_ack_q),
  .desc_wr(desc_wr), .desc_ch(desc_ch), .desc_ready_q(desc_ready_q),
  .irq_enable(irq_enable), .buf_need_q(buf_need_q), .irq_q(irq_q), .hgrant(hgrant),
  .hready(hready), .haddr_q(haddr_q), .htrans_q(htrans_q), .hsize_q(hsize_q),
  .hburst_q(hburst_q)
);

// *** dv/testbench.sv ***
/*
  Self-checking bench for the DMA controller with an AHB memory model.
  Assumes the controller's channel map and descriptor port timing.
*/
`timescale 1ns/1ps
`include "pdma_defines.vh"

module testbench;
  logic core_clk, resetn, slow, desc_wr, desc_sel;
  logic [9:0] per_req, irq_enable;
  logic [95:0] per_rx_data;
  logic [3:0] desc_ch;
  logic [31:0] desc_addr;
  logic [15:0] desc_len;
  logic [1:0] desc_size;
  wire [9:0] per_ack_q, buf_need_q;
  wire [95:0] per_tx_data_q;
  wire desc_ready_q, irq_q, hbusreq_q, hgrant, hready, hwrite_q;
  wire [31:0] hrdata, haddr_q, hwdata_q;
  wire [1:0] htrans_q;
  wire [2:0] hsize_q, hburst_q;
  int err_count, total_checks, cycles;

  peripheral_dma_controller peripheral_dma_controller_inst (.core_clk(core_clk),
    .resetn(resetn), .per_req(per_req), .per_rx_data(per_rx_data), .per_ack_q(per_ack_q),
    .per_tx_data_q(per_tx_data_q), .desc_wr(desc_wr), .desc_ch(desc_ch),
    .desc_sel(desc_sel), .desc_addr(desc_addr), .desc_len(desc_len),
    .desc_size(desc_size), .desc_ready_q(desc_ready_q), .irq_enable(irq_enable),
    .buf_need_q(buf_need_q), .irq_q(irq_q), .hbusreq_q(hbusreq_q), .hgrant(hgrant),
    .hready(hready), .hrdata(hrdata), .haddr_q(haddr_q), .htrans_q(htrans_q),
    .hwrite_q(hwrite_q), .hsize_q(hsize_q), .hburst_q(hburst_q), .hwdata_q(hwdata_q));
  ahb_mem_model ahb_mem_model_inst (.core_clk(core_clk), .resetn(resetn), .slow(slow),
    .hbusreq_q(hbusreq_q), .htrans_q(htrans_q), .haddr_q(haddr_q), .hwrite_q(hwrite_q),
    .hwdata_q(hwdata_q), .hgrant(hgrant), .hready(hready), .hrdata(hrdata));

  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      err_count++;
      close_out();
    end
  end

  task close_out;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task tick(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task check_val(string name, logic [95:0] exp, logic [95:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task put_desc(logic [3:0] ch, logic sel, logic [31:0] a, logic [15:0] l, logic [1:0] sz);
    while (desc_ready_q !== 1'b1)
      tick(1);
    {desc_wr, desc_ch, desc_sel, desc_addr, desc_len, desc_size} = {1'b1, ch, sel, a, l, sz};
    tick(1);
    desc_wr = 1'b0;
    tick(1);
  endtask

  task wait_ack(int ch);
    tick(1);
    for (int i = 0; i < 300 && per_ack_q[ch] !== 1'b1; i++)
      tick(1);
  endtask

  // Write-back cycle marks the end of a unit
  task wait_wb;
    for (int i = 0; i < 300 && desc_ready_q !== 1'b0; i++)
      tick(1);
    tick(2);
  endtask

  task t_rx_usb;
    int acks;
    irq_enable = 10'h002;
    put_desc(4'h1, 1'b0, 32'h00000010, 16'h0004, `SZ_WORD);
    put_desc(4'h1, 1'b1, 32'h00000020, 16'h0004, `SZ_WORD);
    per_rx_data[31:0] = 32'hA5A50001;
    per_req[1] = 1'b1;
    wait_ack(1);
    per_rx_data[31:0] = 32'h5A5A0002;
    wait_ack(1);
    per_req[1] = 1'b0;
    wait_wb();
    check_val("mem sel0", 32'hA5A50001, ahb_mem_model_inst.mem[4]);
    check_val("mem sel1", 32'h5A5A0002, ahb_mem_model_inst.mem[8]);
    check_val("buf need", 10'h002, buf_need_q);
    check_val("irq on", 1'b1, irq_q);
    per_req[1] = 1'b1;
    acks = 0;
    repeat (20)
    begin
      tick(1);
      acks += per_ack_q[1];
    end
    check_val("stalled acks", 0, acks);
    irq_enable = 10'h000;
    tick(2);
    check_val("irq masked", 1'b0, irq_q);
    per_rx_data[31:0] = 32'h00C30003;
    put_desc(4'h1, 1'b0, 32'h00000030, 16'h0004, `SZ_WORD);
    check_val("need cleared", 10'h000, buf_need_q);
    wait_ack(1);
    per_req[1] = 1'b0;
    wait_wb();
    check_val("mem refill", 32'h00C30003, ahb_mem_model_inst.mem[12]);
  endtask

  task t_tx(int ch, logic [31:0] a, logic [1:0] sz, int lsb, logic [31:0] exp);
    put_desc(ch[3:0], 1'b0, a, (sz == `SZ_BYTE) ? 16'h0001 : 16'h0004, sz);
    per_req[ch] = 1'b1;
    wait_ack(ch);
    check_val("tx data", exp, (per_tx_data_q >> lsb) & ((sz == `SZ_BYTE) ? 96'hFF : 96'hFFFFFFFF));
    per_req[ch] = 1'b0;
    wait_wb();
  endtask

  task t_burst_aud;
    put_desc(4'h7, 1'b0, 32'h00000080, 16'h0010, `SZ_QUAD);
    per_req[7] = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      per_rx_data[95:64] = 32'hC0DE0000 + i;
      wait_ack(7);
    end
    per_req[7] = 1'b0;
    wait_wb();
    for (int i = 0; i < 4; i++)
      check_val("burst word", 32'hC0DE0000 + i, ahb_mem_model_inst.mem[32 + i]);
  endtask

  task t_rr;
    logic [9:0] seen;
    put_desc(4'h3, 1'b0, 32'h00000050, 16'h0004, `SZ_WORD);
    put_desc(4'h8, 1'b0, 32'h00000060, 16'h0004, `SZ_WORD);
    per_rx_data = {32'h88880008, 32'h33330003, 32'h0};
    per_req = 10'h108;
    seen = 10'h000;
    for (int i = 0; i < 300 && seen != 10'h108; i++)
    begin
      tick(1);
      seen |= per_ack_q & 10'h108;
    end
    per_req = 10'h000;
    wait_wb();
    check_val("both served", 10'h108, seen);
    check_val("mmc rx", 32'h33330003, ahb_mem_model_inst.mem[20]);
    check_val("aud rx", 32'h88880008, ahb_mem_model_inst.mem[24]);
  endtask

  initial
  begin
    {resetn, slow, desc_wr, desc_sel, per_req, irq_enable, per_rx_data} = '0;
    {desc_ch, desc_addr, desc_len, desc_size} = '0;
    tick(2);
    resetn = 1'b1;
    check_val("reset outs", 0, {hbusreq_q, htrans_q, per_ack_q, buf_need_q, irq_q});
    tick(1);
    t_rx_usb();
    ahb_mem_model_inst.mem[16] = 32'h12345678;
    slow = 1'b1;
    t_tx(2, 32'h00000040, `SZ_WORD, 32, 32'h12345678);
    slow = 1'b0;
    t_tx(4, 32'h00000043, `SZ_BYTE, 64, 32'h00000012);
    t_burst_aud();
    t_rr();
    close_out();
  end
endmodule // testbench

// *** logic/desc_mem.v ***
/*
  Descriptor store: two entries per channel, one write port and one read
  port whose data come out of a register one clock after the address.
  Assumes the caller never needs write-through on the same edge.
*/
`timescale 1ns/1ps
`include "pdma_defines.vh"

module desc_mem (
  core_clk,
  wr_en,
  wr_idx,
  wr_data,
  rd_idx,
  rd_data_q
);
  input  wire                core_clk;
  input  wire                wr_en;
  input  wire [4:0]          wr_idx;
  input  wire [`ENT_W-1:0]   wr_data;
  input  wire [4:0]          rd_idx;
  output reg  [`ENT_W-1:0]   rd_data_q;

  reg [`ENT_W-1:0] mem [0:`MEM_DEPTH-1];

  always @(posedge core_clk)
  begin
    if (wr_en)
      mem[wr_idx] <= wr_data;
    rd_data_q <= mem[rd_idx];
  end
endmodule // desc_mem

// *** logic/pdma_defines.vh ***
/*
  Constants for the peripheral DMA controller: channel map, transfer sizes,
  AHB encodings, descriptor entry layout and state codes.
  Assumes a single core clock domain and an AHB fabric with a
  request/grant arbiter.
*/
// Notes on behaviour
// [RULE_01] Ten DMA channels serve three clients: USB, MMC and audio.
// [RULE_02] USB and MMC each own one transmit and one receive channel.
// [RULE_03] Audio owns six channels: three transmit, three receive.
// [RULE_04] Each client has its own transmit and receive data paths, usable together.
// [RULE_05] All memory accesses go out as master on the system AHB bus.
// [RULE_06] Every channel holds two buffer descriptors, refillable while the other runs.
// [RULE_07] An exhausted buffer switches to the other descriptor, never wrapping.
// [RULE_08] Only peripheral-to-memory and memory-to-peripheral moves; no memory-to-memory.
// [RULE_09] One maskable interrupt while any channel needs a new buffer.
// [RULE_10] Channels move single bytes, single words or four-word bursts.
// [RULE_11] Internal channel arbitration, then external bus grant before each access.
// [RULE_12] Audio transmit data may come from the CPU or audio transmit channels 1-3; the code has no CPU path, only channels 4-6 drive it.
// [RULE_13] Round-robin among requesting channels holding a valid descriptor.
// [RULE_14] Channel without a valid next descriptor stops until software supplies one.
`ifndef PDMA_DEFINES_VH
`define PDMA_DEFINES_VH

`define NUM_CH        10
`define CH_W          4
// Channel map: 0 usb tx, 1 usb rx, 2 mmc tx, 3 mmc rx, 4-6 audio tx, 7-9 audio rx
`define CH_USB_TX     4'h0
`define CH_MMC_TX     4'h2
`define CH_AUD_TX1    4'h4
`define CH_AUD_TX3    4'h6
`define CH_AUD_RX1    4'h7
`define CH_LAST       4'h9

`define CL_USB        2'h0
`define CL_MMC        2'h1
`define CL_AUD        2'h2

// Transfer size codes held in each descriptor
`define SZ_BYTE       2'h0
`define SZ_WORD       2'h1
`define SZ_QUAD       2'h2

// Descriptor entry: {size, length in bytes, address}
`define ENT_W         50
`define ENT_ADDR_LSB  0
`define ENT_LEN_LSB   32
`define ENT_SIZE_LSB  48
`define MEM_DEPTH     20

`define HTRANS_IDLE   2'h0
`define HTRANS_NONSEQ 2'h2
`define HTRANS_SEQ    2'h3
`define HBURST_SINGLE 3'h0
`define HBURST_INCR4  3'h3
`define HSIZE_BYTE    3'h0
`define HSIZE_WORD    3'h2

`define S_IDLE        3'h0
`define S_LOAD        3'h1
`define S_FILL        3'h2
`define S_REQ         3'h3
`define S_XFER        3'h4
`define S_DRAIN       3'h5
`define S_WB          3'h6

`endif

// *** logic/peripheral_dma_controller.v ***
/*
  Ten-channel peripheral DMA engine: per-client transmit/receive data
  paths on one side, an AHB master on the other, two descriptors per
  channel with automatic switching, and a buffer-request interrupt.
  Assumes peripherals hold per_req while they can take or give a whole
  transfer unit, and that the AHB arbiter does not break INCR4 bursts.
*/
`timescale 1ns/1ps
`include "pdma_defines.vh"

module peripheral_dma_controller (
  input  wire         core_clk,
  input  wire         resetn,
  input  wire [9:0]   per_req,
  input  wire [95:0]  per_rx_data,
  output reg  [9:0]   per_ack_q,
  output reg  [95:0]  per_tx_data_q,
  input  wire         desc_wr,
  input  wire [3:0]   desc_ch,
  input  wire         desc_sel,
  input  wire [31:0]  desc_addr,
  input  wire [15:0]  desc_len,
  input  wire [1:0]   desc_size,
  output reg          desc_ready_q,
  input  wire [9:0]   irq_enable,
  output reg  [9:0]   buf_need_q,
  output reg          irq_q,
  output reg          hbusreq_q,
  input  wire         hgrant,
  input  wire         hready,
  input  wire [31:0]  hrdata,
  output reg  [31:0]  haddr_q,
  output reg  [1:0]   htrans_q,
  output reg          hwrite_q,
  output reg  [2:0]   hsize_q,
  output reg  [2:0]   hburst_q,
  output reg  [31:0]  hwdata_q
);

  reg  [2:0]          state_q;
  reg  [3:0]          ch_q;
  reg  [3:0]          rr_q;
  reg  [9:0]          cur_sel_q;
  reg  [19:0]         desc_valid_q;
  reg  [31:0]         addr_q;
  reg  [15:0]         len_q;
  reg  [1:0]          size_q;
  reg  [2:0]          beats_q;
  reg  [2:0]          acnt_q;
  reg  [2:0]          dcnt_q;
  reg  [2:0]          wcnt_q;
  reg                 dph_q;
  reg  [31:0]         qbuf [0:3];
  reg  [9:0]          elig;
  reg  [4:0]          pk;
  reg                 wr_en;
  reg  [4:0]          wr_idx;
  reg  [`ENT_W-1:0]   wr_data;
  wire [4:0]          rd_idx;
  wire [`ENT_W-1:0]   rd_data_q;
  wire [1:0]          cl;
  wire                sw_wr;
  integer             i;
  integer             j;

  // Channel to client and direction; no memory-to-memory path exists
  function [1:0] client;
    input [3:0] ch;
    begin
      if (ch < `CH_MMC_TX)
        client = `CL_USB;                         // RULE_02
      else if (ch < `CH_AUD_TX1)
        client = `CL_MMC;                         // RULE_02
      else
        client = `CL_AUD;                         // RULE_03
    end
  endfunction

  function is_tx;
    input [3:0] ch;
    begin
      if (ch < `CH_AUD_TX1)
        is_tx = ~ch[0];
      else
        is_tx = (ch <= `CH_AUD_TX3);              // RULE_12
    end
  endfunction

  function [4:0] unit_bytes;
    input [1:0] sz;
    begin
      if (sz == `SZ_QUAD)
        unit_bytes = 5'h10;
      else if (sz == `SZ_WORD)
        unit_bytes = 5'h04;
      else
        unit_bytes = 5'h01;
    end
  endfunction

  // Byte reads come back in their lane; move them to the low byte
  function [31:0] rd_fmt;
    input [31:0] d;
    input [1:0]  sz;
    input [1:0]  a;
    reg   [31:0] s;
    begin
      s = d >> {a, 3'h0};
      if (sz == `SZ_BYTE)
        rd_fmt = {24'h000000, s[7:0]};
      else
        rd_fmt = d;
    end
  endfunction

  // Byte writes replicate on all lanes so any slave lane sees it
  function [31:0] wr_fmt;
    input [31:0] d;
    input [1:0]  sz;
    begin
      if (sz == `SZ_BYTE)
        wr_fmt = {4{d[7:0]}};
      else
        wr_fmt = d;
    end
  endfunction

  // Round-robin: search starts just after the last served channel
  function [4:0] pick;
    input [9:0] el;
    input [3:0] last;
    integer     k;
    reg   [3:0] idx;
    begin
      pick = 5'h00;
      idx  = last;
      for (k = 0; k < `NUM_CH; k = k + 1)
      begin
        if (idx == `CH_LAST)
          idx = 4'h0;
        else
          idx = idx + 4'h1;
        if (!pick[4] && el[idx])
          pick = {1'b1, idx};                     // RULE_13
      end
    end
  endfunction

  always @*
  begin
    for (i = 0; i < `NUM_CH; i = i + 1)                               // RULE_01
      elig[i] = per_req[i] & desc_valid_q[{i[3:0], cur_sel_q[i]}];  // RULE_13 RULE_14
    pk = pick(elig, rr_q);                        // RULE_11
  end

  assign rd_idx = {pk[3:0], cur_sel_q[pk[3:0]]};
  assign cl     = client(ch_q);
  assign sw_wr  = desc_wr & desc_ready_q;

  // Engine write-back owns the port in S_WB; software is held off by desc_ready_q
  always @*
  begin
    wr_en   = 1'b0;
    wr_idx  = {desc_ch, desc_sel};
    wr_data = {desc_size, desc_len, desc_addr};
    if (state_q == `S_WB)
    begin
      wr_en   = 1'b1;
      wr_idx  = {ch_q, cur_sel_q[ch_q]};
      wr_data = {size_q, len_q, addr_q};
    end
    else if (sw_wr)
      wr_en = 1'b1;                               // RULE_06
  end

  desc_mem u_desc_mem (
    .core_clk  (core_clk),
    .wr_en     (wr_en),
    .wr_idx    (wr_idx),
    .wr_data   (wr_data),
    .rd_idx    (rd_idx),
    .rd_data_q (rd_data_q)
  );

  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      state_q       <= `S_IDLE;
      ch_q          <= 4'h0;
      rr_q          <= `CH_LAST;
      cur_sel_q     <= 10'h000;
      desc_valid_q  <= 20'h00000;
      addr_q        <= 32'h00000000;
      len_q         <= 16'h0000;
      size_q        <= `SZ_BYTE;
      beats_q       <= 3'h1;
      acnt_q        <= 3'h0;
      dcnt_q        <= 3'h0;
      wcnt_q        <= 3'h0;
      dph_q         <= 1'b0;
      per_ack_q     <= 10'h000;
      per_tx_data_q <= 96'h000000000000000000000000;
      desc_ready_q  <= 1'b0;
      buf_need_q    <= 10'h000;
      irq_q         <= 1'b0;
      hbusreq_q     <= 1'b0;
      haddr_q       <= 32'h00000000;
      htrans_q      <= `HTRANS_IDLE;
      hwrite_q      <= 1'b0;
      hsize_q       <= `HSIZE_BYTE;
      hburst_q      <= `HBURST_SINGLE;
      hwdata_q      <= 32'h00000000;
      for (j = 0; j < 4; j = j + 1)
        qbuf[j] <= 32'h00000000;
    end
    else
    begin
      per_ack_q    <= 10'h000;
      desc_ready_q <= 1'b1;
      irq_q        <= |(buf_need_q & irq_enable); // RULE_09
      if (sw_wr && state_q != `S_WB)
      begin
        desc_valid_q[{desc_ch, desc_sel}] <= 1'b1;  // RULE_06
        buf_need_q[desc_ch]               <= 1'b0;
      end
      case (state_q)
        `S_IDLE:
        begin
          if (pk[4])
          begin
            ch_q    <= pk[3:0];
            rr_q    <= pk[3:0];                   // RULE_13
            state_q <= `S_LOAD;
          end
        end
        `S_LOAD:
        begin
          addr_q  <= rd_data_q[`ENT_ADDR_LSB +: 32];
          len_q   <= rd_data_q[`ENT_LEN_LSB +: 16];
          size_q  <= rd_data_q[`ENT_SIZE_LSB +: 2];
          beats_q <= (rd_data_q[`ENT_SIZE_LSB +: 2] == `SZ_QUAD) ? 3'h4 : 3'h1;  // RULE_10
          wcnt_q  <= 3'h0;
          if (rd_data_q[`ENT_LEN_LSB +: 16] == 16'h0000)
          begin
            // Empty buffer: retire it without touching the bus
            desc_ready_q <= 1'b0;
            state_q      <= `S_WB;
          end
          else if (is_tx(ch_q))
          begin
            hbusreq_q <= 1'b1;                    // RULE_11
            state_q   <= `S_REQ;
          end
          else
            state_q <= `S_FILL;
        end
        `S_FILL:
        begin
          // One-cycle gap after each ack lets the client present the next word
          if (per_req[ch_q] && !per_ack_q[ch_q])
          begin
            qbuf[wcnt_q[1:0]] <= per_rx_data[{cl, 5'h00} +: 32];  // RULE_04
            per_ack_q[ch_q]   <= 1'b1;
            wcnt_q            <= wcnt_q + 3'h1;
            if (wcnt_q == beats_q - 3'h1)
            begin
              hbusreq_q <= 1'b1;                  // RULE_11
              state_q   <= `S_REQ;
            end
          end
        end
        `S_REQ:
        begin
          if (hgrant && hready)
          begin
            haddr_q   <= addr_q;                  // RULE_05
            htrans_q  <= `HTRANS_NONSEQ;
            hwrite_q  <= ~is_tx(ch_q);            // RULE_08
            hsize_q   <= (size_q == `SZ_BYTE) ? `HSIZE_BYTE : `HSIZE_WORD;  // RULE_10
            hburst_q  <= (size_q == `SZ_QUAD) ? `HBURST_INCR4 : `HBURST_SINGLE;
            hbusreq_q <= (beats_q != 3'h1);
            acnt_q    <= 3'h1;
            dcnt_q    <= 3'h0;
            dph_q     <= 1'b0;
            state_q   <= `S_XFER;
          end
        end
        `S_XFER:
        begin
          if (hready)
          begin
            if (htrans_q != `HTRANS_IDLE)
            begin
              dph_q    <= 1'b1;
              hwdata_q <= wr_fmt(qbuf[acnt_q[1:0] - 2'h1], size_q);
              if (acnt_q < beats_q)
              begin
                haddr_q  <= haddr_q + 32'h00000004;
                htrans_q <= `HTRANS_SEQ;
                acnt_q   <= acnt_q + 3'h1;
                if (acnt_q == beats_q - 3'h1)
                  hbusreq_q <= 1'b0;
              end
              else
                htrans_q <= `HTRANS_IDLE;
            end
            else
              dph_q <= 1'b0;
            if (dph_q)
            begin
              if (!hwrite_q)
                qbuf[dcnt_q[1:0]] <= rd_fmt(hrdata, size_q, haddr_q[1:0]);
              dcnt_q <= dcnt_q + 3'h1;
              if (dcnt_q == beats_q - 3'h1)
              begin
                // Buffer advances; it never wraps to its start
                addr_q <= addr_q + {27'h0000000, unit_bytes(size_q)};  // RULE_07
                len_q  <= len_q - {11'h000, unit_bytes(size_q)};
                wcnt_q <= 3'h0;
                if (hwrite_q)
                begin
                  desc_ready_q <= 1'b0;
                  state_q      <= `S_WB;
                end
                else
                  state_q <= `S_DRAIN;
              end
            end
          end
        end
        `S_DRAIN:
        begin
          if (!per_ack_q[ch_q])
          begin
            per_tx_data_q[{cl, 5'h00} +: 32] <= qbuf[wcnt_q[1:0]];  // RULE_04 RULE_12
            per_ack_q[ch_q] <= 1'b1;
            wcnt_q          <= wcnt_q + 3'h1;
            if (wcnt_q == beats_q - 3'h1)
            begin
              desc_ready_q <= 1'b0;
              state_q      <= `S_WB;
            end
          end
        end
        `S_WB:
        begin
          if (len_q == 16'h0000)
          begin
            // Switch to the other descriptor; it stalls there if not valid
            desc_valid_q[{ch_q, cur_sel_q[ch_q]}] <= 1'b0;  // RULE_07 RULE_14
            cur_sel_q[ch_q]  <= ~cur_sel_q[ch_q];           // RULE_07
            buf_need_q[ch_q] <= 1'b1;                       // RULE_09
          end
          state_q <= `S_IDLE;
        end
        default:
          state_q <= `S_IDLE;
      endcase
    end
  end
endmodule // peripheral_dma_controller
